// [beuh_dly_resp.v]
`timescale 1ns/1ps
`include "beuh_regs.vh"
module beuh_dly_resp
(
	// clock and reset
	input  wire        i_sys_clk,
	input  wire        i_rst_b,
	// mode
	input  wire        i_mam,
	// primary completion of delayed transaction
	input  wire        i_dly_vld,
	input  wire        i_dly_io_wr,
	input  wire [1:0]  i_dly_sts,
	input  wire [31:0] i_dly_data,
	// secondary response
	output reg         o_rsp_vld,
	output reg         o_rsp_tabort,
	output reg         o_rsp_normal,
	output reg  [31:0] o_rsp_data
);

// ************************************************************
// response mapping
// ************************************************************
wire is_ur = (i_dly_sts == `BEUH_CS_UR);
wire is_ca = (i_dly_sts == `BEUH_CS_CA);
wire tab   = is_ca | (is_ur & i_mam); // RULE_11 RULE_13
wire ones  = is_ur & ~i_mam & ~i_dly_io_wr; // RULE_11

always @(posedge i_sys_clk or negedge i_rst_b)
begin
	if (!i_rst_b)
	begin
		o_rsp_vld    <= 1'b0;
		o_rsp_tabort <= 1'b0;
		o_rsp_normal <= 1'b0;
		o_rsp_data   <= `BEUH_ZERO;
	end
	else
	begin
		o_rsp_vld    <= i_dly_vld;
		o_rsp_tabort <= i_dly_vld & tab;
		o_rsp_normal <= i_dly_vld & ~tab; // RULE_12
		o_rsp_data   <= ones ? `BEUH_ONES : i_dly_data;
	end
end

endmodule // beuh_dly_resp

// [beuh_far_model.sv]
`timescale 1ns/1ps
module beuh_far_model
(
	// clock
	input  wire        i_sys_clk,
	// link events
	output reg  [3:0]  o_ev = 4'h0,
	// secondary transactions
	output reg         o_sec_vld = 1'b0,
	output reg  [1:0]  o_sec_kind = 2'h0,
	output reg         o_sec_perr = 1'b0,
	// delayed completions
	output reg         o_dly_vld = 1'b0,
	output reg         o_dly_io_wr = 1'b0,
	output reg  [1:0]  o_dly_sts = 2'h0,
	output reg  [31:0] o_dly_data = 32'h0000_0000
);
	// ****
	// one-cycle pulses; sec and dly leave idle payload lines inverted, ev returns to zero
	// ****
	task ev(input [3:0] m);
	begin
		o_ev <= m;
		@(posedge i_sys_clk);
		o_ev <= 4'h0;
	end
	endtask
	task sec(input [1:0] k, input p, input more);
	begin
		o_sec_vld <= 1'b1;
		o_sec_kind <= k;
		o_sec_perr <= p;
		@(posedge i_sys_clk);
		if (!more)
			{o_sec_vld, o_sec_kind, o_sec_perr} <= {1'b0, ~k, ~p};
	end
	endtask
	task dly(input io, input [1:0] s, input [31:0] d, input more);
	begin
		{o_dly_vld, o_dly_io_wr, o_dly_sts, o_dly_data} <= {1'b1, io, s, d};
		@(posedge i_sys_clk);
		if (!more)
			{o_dly_vld, o_dly_io_wr, o_dly_sts, o_dly_data} <=
				{1'b0, ~io, ~s, ~d};
	end
	endtask
endmodule // beuh_far_model

// [beuh_fwd_map.v]
`timescale 1ns/1ps
`include "beuh_regs.vh"
module beuh_fwd_map
(
	// clock and reset
	input  wire       i_sys_clk,
	input  wire       i_rst_b,
	// secondary transaction
	input  wire       i_sec_vld,
	input  wire [1:0] i_sec_kind,
	input  wire       i_sec_perr,
	// forwarded upstream
	output reg        o_fwd_vld,
	output reg  [1:0] o_fwd_kind,
	output reg        o_fwd_poison,
	output reg        o_fwd_ca
);

// ************************************************************
// error translation
// ************************************************************
wire is_data = (i_sec_kind == `BEUH_K_WR) | (i_sec_kind == `BEUH_K_RDC);
wire is_cpl  = (i_sec_kind == `BEUH_K_CIO) | (i_sec_kind == `BEUH_K_SCM);

always @(posedge i_sys_clk or negedge i_rst_b)
begin
	if (!i_rst_b)
	begin
		o_fwd_vld    <= 1'b0;
		o_fwd_kind   <= `BEUH_K_WR;
		o_fwd_poison <= 1'b0;
		o_fwd_ca     <= 1'b0;
	end
	else
	begin
		o_fwd_vld    <= i_sec_vld;
		o_fwd_kind   <= i_sec_kind;
		o_fwd_poison <= i_sec_vld & i_sec_perr & is_data; // RULE_08 RULE_09
		o_fwd_ca     <= i_sec_vld & i_sec_perr & is_cpl; // RULE_10
	end
end

endmodule // beuh_fwd_map

// [beuh_regs.vh]
// Behaviour
// (RULE_01) link protocol violation sets its uncorrectable status flag
// (RULE_02) flow control protocol violation sets its uncorrectable status flag
// (RULE_03) receive buffer overflow sets the receiver overflow status flag
// (RULE_04) malformed packet sets the malformed packet status flag
// (RULE_05) unmasked error with serr or matching enable sends fatal/nonfatal msg
// (RULE_06) every error sets fatal or nonfatal detected flag by severity
// (RULE_07) signaled system error set when unmasked and serr enable set
// (RULE_08) secondary write with parity error forwarded as poisoned write
// (RULE_09) read completion with data parity error forwarded as poisoned
// (RULE_10) config/io completion or split msg with error gets completer abort
// (RULE_11) read returning unsupported: target abort if mode 1, else all ones
// (RULE_12) io write returning unsupported with mode 0 completes normally
// (RULE_13) completer abort from primary gives target abort to secondary
// (RULE_14) severity one selects fatal message, zero selects nonfatal
`ifndef BEUH_REGS_VH
`define BEUH_REGS_VH

// ************************************************************
// register offsets and indices
// ************************************************************
`define BEUH_AW        8
`define BEUH_OFS_STAT  8'h00
`define BEUH_OFS_MASK  8'h04
`define BEUH_OFS_SEV   8'h08
`define BEUH_OFS_IMASK 8'h0c
`define BEUH_OFS_CTRL  8'h10
`define BEUH_OFS_DSTAT 8'h14
`define BEUH_IX_STAT   3'h0
`define BEUH_IX_MASK   3'h1
`define BEUH_IX_SEV    3'h2
`define BEUH_IX_IMASK  3'h3
`define BEUH_IX_CTRL   3'h4
`define BEUH_IX_DSTAT  3'h5
`define BEUH_IX_NONE   3'h7

// ************************************************************
// field positions
// ************************************************************
`define BEUH_B_DLP     0
`define BEUH_B_FCP     1
`define BEUH_B_ROF     2
`define BEUH_B_MTLP    3
`define BEUH_C_SERR    0
`define BEUH_C_FATEN   1
`define BEUH_C_NFEN    2
`define BEUH_C_MAM     3
`define BEUH_D_FAT     0
`define BEUH_D_NF      1
`define BEUH_D_SSE     2

// ************************************************************
// reset values and encodings
// ************************************************************
`define BEUH_STAT_RST  4'h0
`define BEUH_MASK_RST  4'h0
`define BEUH_SEV_RST   4'hf
`define BEUH_IMASK_RST 4'h0
`define BEUH_CTRL_RST  4'h0
`define BEUH_DSTAT_RST 3'h0
`define BEUH_RESP_OK   2'h0
`define BEUH_RESP_ERR  2'h2
`define BEUH_K_WR      2'h0
`define BEUH_K_RDC     2'h1
`define BEUH_K_CIO     2'h2
`define BEUH_K_SCM     2'h3
`define BEUH_CS_SC     2'h0
`define BEUH_CS_UR     2'h1
`define BEUH_CS_CA     2'h2
`define BEUH_ONES      32'hffff_ffff
`define BEUH_ZERO      32'h0000_0000

`endif

// [beuh_top.v]
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "beuh_regs.vh"
module beuh_top
(
	// clock and reset
	input  wire                i_sys_clk,
	input  wire                i_rst_b,
	// axi4-lite write address
	input  wire [`BEUH_AW-1:0] i_awaddr,
	input  wire                i_awvalid,
	output wire                o_awready,
	// axi4-lite write data
	input  wire [31:0]         i_wdata,
	input  wire [3:0]          i_wstrb,
	input  wire                i_wvalid,
	output wire                o_wready,
	// axi4-lite write response
	output wire [1:0]          o_bresp,
	output wire                o_bvalid,
	input  wire                i_bready,
	// axi4-lite read address
	input  wire [`BEUH_AW-1:0] i_araddr,
	input  wire                i_arvalid,
	output wire                o_arready,
	// axi4-lite read data
	output wire [31:0]         o_rdata,
	output wire [1:0]          o_rresp,
	output wire                o_rvalid,
	input  wire                i_rready,
	// primary link error events
	input  wire                i_dlp_err,
	input  wire                i_fcp_err,
	input  wire                i_rx_ovf,
	input  wire                i_bad_tlp,
	// error messages upstream
	output wire                o_msg_fatal,
	output wire                o_msg_nonfatal,
	// secondary to primary forwarding
	input  wire                i_sec_vld,
	input  wire [1:0]          i_sec_kind,
	input  wire                i_sec_perr,
	output wire                o_fwd_vld,
	output wire [1:0]          o_fwd_kind,
	output wire                o_fwd_poison,
	output wire                o_fwd_ca,
	// delayed transaction completions
	input  wire                i_dly_vld,
	input  wire                i_dly_io_wr,
	input  wire [1:0]          i_dly_sts,
	input  wire [31:0]         i_dly_data,
	output wire                o_dly_rsp_vld,
	output wire                o_dly_tabort,
	output wire                o_dly_normal,
	output wire [31:0]         o_dly_data,
	// interrupt
	output wire                o_irq
);

// ************************************************************
// address decode
// ************************************************************
function [2:0] beuh_dec;
	input [`BEUH_AW-1:0] a;
	begin
		case (a)
			`BEUH_OFS_STAT:  beuh_dec = `BEUH_IX_STAT;
			`BEUH_OFS_MASK:  beuh_dec = `BEUH_IX_MASK;
			`BEUH_OFS_SEV:   beuh_dec = `BEUH_IX_SEV;
			`BEUH_OFS_IMASK: beuh_dec = `BEUH_IX_IMASK;
			`BEUH_OFS_CTRL:  beuh_dec = `BEUH_IX_CTRL;
			`BEUH_OFS_DSTAT: beuh_dec = `BEUH_IX_DSTAT;
			default:         beuh_dec = `BEUH_IX_NONE;
		endcase
	end
endfunction

// ************************************************************
// bus state
// ************************************************************
reg                awready_ff;
reg                wready_ff;
reg                aw_hold_ff;
reg                w_hold_ff;
reg [`BEUH_AW-1:0] awaddr_ff;
reg [31:0]         wdata_ff;
reg                wlane_ff;
reg                bvalid_ff;
reg [1:0]          bresp_ff;
reg                arready_ff;
reg                rvalid_ff;
reg [31:0]         rdata_ff;
reg [1:0]          rresp_ff;
reg                nxt_aw_hold;
reg                nxt_w_hold;
reg                nxt_bvalid;
reg                nxt_rvalid;

wire       aw_take = i_awvalid & awready_ff;
wire       w_take  = i_wvalid & wready_ff;
wire       ar_take = i_arvalid & arready_ff;
wire       do_wr   = aw_hold_ff & w_hold_ff & ~bvalid_ff;
wire [2:0] wr_idx  = beuh_dec(awaddr_ff);
wire [2:0] rd_idx  = beuh_dec(i_araddr);

// ************************************************************
// error registers
// ************************************************************
reg  [3:0] stat_ff;
reg  [3:0] mask_ff;
reg  [3:0] sev_ff;
reg  [3:0] imask_ff;
reg  [3:0] ctrl_ff;
reg  [2:0] dstat_ff;
reg        msg_fat_ff;
reg        msg_nf_ff;
reg        irq_ff;
reg  [3:0] nxt_stat;
reg  [3:0] nxt_mask;
reg  [3:0] nxt_sev;
reg  [3:0] nxt_imask;
reg  [3:0] nxt_ctrl;
reg  [2:0] nxt_dstat;
reg  [31:0] rd_val;

wire [3:0] evt;
wire [3:0] unm;
wire       serr_en = ctrl_ff[`BEUH_C_SERR];
wire       fat_en  = ctrl_ff[`BEUH_C_FATEN];
wire       nf_en   = ctrl_ff[`BEUH_C_NFEN];

assign evt[`BEUH_B_DLP]  = i_dlp_err; // RULE_01
assign evt[`BEUH_B_FCP]  = i_fcp_err; // RULE_02
assign evt[`BEUH_B_ROF]  = i_rx_ovf; // RULE_03
assign evt[`BEUH_B_MTLP] = i_bad_tlp; // RULE_04
assign unm = evt & ~mask_ff;

// severity one is fatal, zero nonfatal
wire fat_any = |(evt & sev_ff); // RULE_06 RULE_14
wire nf_any  = |(evt & ~sev_ff); // RULE_06 RULE_14
wire fat_unm = |(unm & sev_ff); // RULE_14
wire nf_unm  = |(unm & ~sev_ff); // RULE_14
wire fat_msg = fat_unm & (serr_en | fat_en); // RULE_05
wire nf_msg  = nf_unm & (serr_en | nf_en); // RULE_05
wire sse_set = (|unm) & serr_en; // RULE_07

wire rd_stat  = ar_take & (rd_idx == `BEUH_IX_STAT);
wire rd_dstat = ar_take & (rd_idx == `BEUH_IX_DSTAT);

// ************************************************************
// next register values
// ************************************************************
always @*
begin
	nxt_mask  = mask_ff;
	nxt_sev   = sev_ff;
	nxt_imask = imask_ff;
	nxt_ctrl  = ctrl_ff;
	if (do_wr & wlane_ff)
	begin
		case (wr_idx)
			`BEUH_IX_MASK:  nxt_mask  = wdata_ff[3:0];
			`BEUH_IX_SEV:   nxt_sev   = wdata_ff[3:0];
			`BEUH_IX_IMASK: nxt_imask = wdata_ff[3:0];
			`BEUH_IX_CTRL:  nxt_ctrl  = wdata_ff[3:0];
			default:        nxt_ctrl  = ctrl_ff;
		endcase
	end
	// set wins over read clear
	nxt_stat = (stat_ff & ~{4{rd_stat}}) | evt; // RULE_01 RULE_02 RULE_03 RULE_04
	nxt_dstat = dstat_ff & ~{3{rd_dstat}};
	nxt_dstat[`BEUH_D_FAT] = nxt_dstat[`BEUH_D_FAT] | fat_any; // RULE_06
	nxt_dstat[`BEUH_D_NF]  = nxt_dstat[`BEUH_D_NF] | nf_any; // RULE_06
	nxt_dstat[`BEUH_D_SSE] = nxt_dstat[`BEUH_D_SSE] | sse_set; // RULE_07
end

// ************************************************************
// read mux
// ************************************************************
always @*
begin
	rd_val = `BEUH_ZERO;
	case (rd_idx)
		`BEUH_IX_STAT:  rd_val[3:0] = stat_ff;
		`BEUH_IX_MASK:  rd_val[3:0] = mask_ff;
		`BEUH_IX_SEV:   rd_val[3:0] = sev_ff;
		`BEUH_IX_IMASK: rd_val[3:0] = imask_ff;
		`BEUH_IX_CTRL:  rd_val[3:0] = ctrl_ff;
		`BEUH_IX_DSTAT: rd_val[2:0] = dstat_ff;
		default:        rd_val = `BEUH_ZERO;
	endcase
end

// ************************************************************
// bus handshake next state
// ************************************************************
always @*
begin
	nxt_aw_hold = (aw_hold_ff | aw_take) & ~do_wr;
	nxt_w_hold  = (w_hold_ff | w_take) & ~do_wr;
	nxt_bvalid  = do_wr | (bvalid_ff & ~i_bready);
	nxt_rvalid  = ar_take | (rvalid_ff & ~i_rready);
end

always @(posedge i_sys_clk or negedge i_rst_b)
begin
	if (!i_rst_b)
	begin
		awready_ff <= 1'b0;
		wready_ff  <= 1'b0;
		aw_hold_ff <= 1'b0;
		w_hold_ff  <= 1'b0;
		awaddr_ff  <= `BEUH_OFS_STAT;
		wdata_ff   <= `BEUH_ZERO;
		wlane_ff   <= 1'b0;
		bvalid_ff  <= 1'b0;
		bresp_ff   <= `BEUH_RESP_OK;
		arready_ff <= 1'b0;
		rvalid_ff  <= 1'b0;
		rdata_ff   <= `BEUH_ZERO;
		rresp_ff   <= `BEUH_RESP_OK;
	end
	else
	begin
		aw_hold_ff <= nxt_aw_hold;
		w_hold_ff  <= nxt_w_hold;
		awready_ff <= ~nxt_aw_hold & ~nxt_bvalid;
		wready_ff  <= ~nxt_w_hold & ~nxt_bvalid;
		bvalid_ff  <= nxt_bvalid;
		arready_ff <= ~nxt_rvalid;
		rvalid_ff  <= nxt_rvalid;
		if (aw_take)
			awaddr_ff <= i_awaddr;
		if (w_take)
		begin
			wdata_ff <= i_wdata;
			wlane_ff <= i_wstrb[0];
		end
		if (do_wr)
			bresp_ff <= (wr_idx == `BEUH_IX_NONE) ?
				`BEUH_RESP_ERR : `BEUH_RESP_OK;
		if (ar_take)
		begin
			rdata_ff <= rd_val;
			rresp_ff <= (rd_idx == `BEUH_IX_NONE) ?
				`BEUH_RESP_ERR : `BEUH_RESP_OK;
		end
	end
end

// ************************************************************
// register and message flops
// ************************************************************
always @(posedge i_sys_clk or negedge i_rst_b)
begin
	if (!i_rst_b)
	begin
		stat_ff    <= `BEUH_STAT_RST;
		mask_ff    <= `BEUH_MASK_RST;
		sev_ff     <= `BEUH_SEV_RST;
		imask_ff   <= `BEUH_IMASK_RST;
		ctrl_ff    <= `BEUH_CTRL_RST;
		dstat_ff   <= `BEUH_DSTAT_RST;
		msg_fat_ff <= 1'b0;
		msg_nf_ff  <= 1'b0;
		irq_ff     <= 1'b0;
	end
	else
	begin
		stat_ff    <= nxt_stat;
		mask_ff    <= nxt_mask;
		sev_ff     <= nxt_sev;
		imask_ff   <= nxt_imask;
		ctrl_ff    <= nxt_ctrl;
		dstat_ff   <= nxt_dstat;
		msg_fat_ff <= fat_msg; // RULE_05
		msg_nf_ff  <= nf_msg; // RULE_05
		irq_ff     <= |(nxt_stat & nxt_imask);
	end
end

// ************************************************************
// secondary forwarding and delayed responses
// ************************************************************
beuh_fwd_map u_fwd
(
	.i_sys_clk    (i_sys_clk),
	.i_rst_b      (i_rst_b),
	.i_sec_vld    (i_sec_vld),
	.i_sec_kind   (i_sec_kind),
	.i_sec_perr   (i_sec_perr),
	.o_fwd_vld    (o_fwd_vld),
	.o_fwd_kind   (o_fwd_kind),
	.o_fwd_poison (o_fwd_poison),
	.o_fwd_ca     (o_fwd_ca)
);

beuh_dly_resp u_dly
(
	.i_sys_clk    (i_sys_clk),
	.i_rst_b      (i_rst_b),
	.i_mam        (ctrl_ff[`BEUH_C_MAM]),
	.i_dly_vld    (i_dly_vld),
	.i_dly_io_wr  (i_dly_io_wr),
	.i_dly_sts    (i_dly_sts),
	.i_dly_data   (i_dly_data),
	.o_rsp_vld    (o_dly_rsp_vld),
	.o_rsp_tabort (o_dly_tabort),
	.o_rsp_normal (o_dly_normal),
	.o_rsp_data   (o_dly_data)
);

// ************************************************************
// outputs
// ************************************************************
assign o_awready      = awready_ff;
assign o_wready       = wready_ff;
assign o_bresp        = bresp_ff;
assign o_bvalid       = bvalid_ff;
assign o_arready      = arready_ff;
assign o_rdata        = rdata_ff;
assign o_rresp        = rresp_ff;
assign o_rvalid       = rvalid_ff;
assign o_msg_fatal    = msg_fat_ff;
assign o_msg_nonfatal = msg_nf_ff;
assign o_irq          = irq_ff;

endmodule // beuh_top

// [beuh_top_properties.sv]
`timescale 1ns/1ps
`include "beuh_regs.vh"
module beuh_top_chk
(
	// clock and reset
	input wire        i_sys_clk,
	input wire        i_rst_b,
	// register bus
	input wire        i_awvalid,
	input wire        o_awready,
	input wire        i_wvalid,
	input wire        o_wready,
	input wire        o_bvalid,
	input wire        i_arvalid,
	input wire        o_arready,
	input wire        o_rvalid,
	// link events and messages
	input wire        i_dlp_err,
	input wire        i_fcp_err,
	input wire        i_rx_ovf,
	input wire        i_bad_tlp,
	input wire        o_msg_fatal,
	input wire        o_msg_nonfatal,
	// forwarding
	input wire        i_sec_vld,
	input wire [1:0]  i_sec_kind,
	input wire        i_sec_perr,
	input wire        o_fwd_vld,
	input wire [1:0]  o_fwd_kind,
	input wire        o_fwd_poison,
	input wire        o_fwd_ca,
	// delayed completions
	input wire        i_dly_vld,
	input wire        i_dly_io_wr,
	input wire [1:0]  i_dly_sts,
	input wire        o_dly_rsp_vld,
	input wire        o_dly_tabort,
	input wire        o_dly_normal,
	input wire [31:0] o_dly_data
);
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_b);
	// ****
	// handshakes
	// ****
	sequence wr_take;
		i_awvalid && o_awready && i_wvalid && o_wready;
	endsequence
	sequence b_late;
		!o_bvalid ##1 o_bvalid;
	endsequence
	write_resp_a:
	assert property (wr_take |=> b_late) else $error("write answer late");
	read_resp_a:
	assert property (i_arvalid && o_arready |=> o_rvalid && !o_arready)
		else $error("read answer late");
	// ****
	// errors and forwarding
	// ****
	msg_cause_a:
	assert property (o_msg_fatal || o_msg_nonfatal |->
		$past(i_dlp_err || i_fcp_err || i_rx_ovf || i_bad_tlp))
		else $error("message without event");
	fwd_answer_a:
	assert property (i_sec_vld |=> o_fwd_vld && o_fwd_kind == $past(i_sec_kind))
		else $error("forward missing");
	fwd_poison_a:
	assert property (i_sec_vld && i_sec_perr && !i_sec_kind[1] |=>
		o_fwd_poison && !o_fwd_ca) else $error("poison missing");
	fwd_abort_a:
	assert property (i_sec_vld && i_sec_perr && i_sec_kind[1] |=>
		o_fwd_ca && !o_fwd_poison) else $error("abort status missing");
	fwd_clean_a:
	assert property (i_sec_vld && !i_sec_perr |=> !o_fwd_poison && !o_fwd_ca)
		else $error("clean forward marked");
	ca_abort_a:
	assert property (i_dly_vld && i_dly_sts == `BEUH_CS_CA |=>
		o_dly_rsp_vld && o_dly_tabort && !o_dly_normal)
		else $error("completer abort not aborted");
	ur_answer_a:
	assert property (i_dly_vld && i_dly_sts == `BEUH_CS_UR |=> o_dly_rsp_vld
		&& o_dly_tabort != o_dly_normal && (!o_dly_normal
		|| $past(i_dly_io_wr) || o_dly_data == `BEUH_ONES))
		else $error("unsupported answer wrong");
	dly_idle_a:
	assert property (!i_dly_vld |=> !o_dly_rsp_vld) else $error("stray response");
endmodule // beuh_top_chk
bind beuh_top beuh_top_chk i_chk (.i_sys_clk, .i_rst_b, .i_awvalid, .o_awready,
	.i_wvalid, .o_wready, .o_bvalid, .i_arvalid, .o_arready, .o_rvalid,
	.i_dlp_err, .i_fcp_err, .i_rx_ovf, .i_bad_tlp, .o_msg_fatal,
	.o_msg_nonfatal, .i_sec_vld, .i_sec_kind, .i_sec_perr, .o_fwd_vld,
	.o_fwd_kind, .o_fwd_poison, .o_fwd_ca, .i_dly_vld, .i_dly_io_wr,
	.i_dly_sts, .o_dly_rsp_vld, .o_dly_tabort, .o_dly_normal, .o_dly_data);

// [beuh_top_tb.sv]
`timescale 1ns/1ps
`include "beuh_regs.vh"
module beuh_top_tb;
	reg         i_sys_clk = 1'b0;
	reg         i_rst_b   = 1'b0;
	reg  [7:0]  i_awaddr  = 8'h00;
	reg         i_awvalid = 1'b0;
	reg  [31:0] i_wdata   = 32'h0000_0000;
	reg  [3:0]  i_wstrb   = 4'hf;
	reg         i_wvalid  = 1'b0;
	reg         i_bready  = 1'b0;
	reg  [7:0]  i_araddr  = 8'h00;
	reg         i_arvalid = 1'b0;
	reg         i_rready  = 1'b0;
	wire        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
	wire [1:0]  o_bresp, o_rresp, o_fwd_kind, i_sec_kind, i_dly_sts;
	wire [31:0] o_rdata, o_dly_data, i_dly_data;
	wire        i_dlp_err, i_fcp_err, i_rx_ovf, i_bad_tlp, o_msg_fatal;
	wire        o_msg_nonfatal, i_sec_vld, i_sec_perr, o_fwd_vld, o_fwd_poison;
	wire        o_fwd_ca, i_dly_vld, i_dly_io_wr, o_dly_rsp_vld, o_dly_tabort;
	wire        o_dly_normal;
	logic [35:0] q [4][$];
	reg  [3:0]  ctl, mk, sev, evm, e_st;
	reg  [2:0]  e_ds;
	reg  [15:0] cs [0:9];
	reg  [31:0] rnd = 32'h0000_0050;
	reg         tab;
	integer     err_total = 0, compares = 0, cyc = 0, j, m;
	beuh_top i_beuh_top (.i_sys_clk, .i_rst_b, .i_awaddr, .i_awvalid,
		.o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp,
		.o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata,
		.o_rresp, .o_rvalid, .i_rready, .i_dlp_err, .i_fcp_err, .i_rx_ovf,
		.i_bad_tlp, .o_msg_fatal, .o_msg_nonfatal, .i_sec_vld, .i_sec_kind,
		.i_sec_perr, .o_fwd_vld, .o_fwd_kind, .o_fwd_poison, .o_fwd_ca,
		.i_dly_vld, .i_dly_io_wr, .i_dly_sts, .i_dly_data, .o_dly_rsp_vld,
		.o_dly_tabort, .o_dly_normal, .o_dly_data, .o_irq);
	beuh_far_model i_far (.i_sys_clk,
		.o_ev({i_bad_tlp, i_rx_ovf, i_fcp_err, i_dlp_err}),
		.o_sec_vld(i_sec_vld), .o_sec_kind(i_sec_kind), .o_sec_perr(i_sec_perr),
		.o_dly_vld(i_dly_vld), .o_dly_io_wr(i_dly_io_wr),
		.o_dly_sts(i_dly_sts), .o_dly_data(i_dly_data));
	// ****
	// helpers
	// ****
	function [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function [35:0] pop(input integer w);
		pop = q[w].size() ? q[w].pop_front() : 'x;
	endfunction
	task chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
	begin
		compares = compares + 1;
		if (seen !== exp)
		begin
			err_total = err_total + 1;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	end
	endtask
	task end_of_test;
	begin
		if (err_total == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	end
	endtask
	task wr(input [7:0] a, input [3:0] d, input [1:0] r);
		reg pa, pw;
	begin
		{pa, pw} = 2'h3;
		{i_awaddr, i_wdata, i_awvalid, i_wvalid} <= {a, 28'h000_0000, d, 2'h3};
		q[3].push_back({r, 32'h0000_0000});
		while (pa | pw)
		begin
			@(posedge i_sys_clk);
			if (pa && o_awready)
				i_awvalid <= 1'b0;
			if (pw && o_wready)
				i_wvalid <= 1'b0;
			{pa, pw} = {pa & ~o_awready, pw & ~o_wready};
		end
		i_bready <= 1'b1;
		@(posedge i_sys_clk);
		while (!o_bvalid)
			@(posedge i_sys_clk);
		i_bready <= 1'b0;
	end
	endtask
	task rd(input [7:0] a, input [31:0] d, input [1:0] r);
	begin
		{i_araddr, i_arvalid} <= {a, 1'b1};
		q[3].push_back({r, d});
		@(posedge i_sys_clk);
		while (!o_arready)
			@(posedge i_sys_clk);
		{i_arvalid, i_rready} <= 2'h1;
		@(posedge i_sys_clk);
		while (!o_rvalid)
			@(posedge i_sys_clk);
		i_rready <= 1'b0;
	end
	endtask
	task fire(input [3:0] e);
		reg f, n;
	begin
		f = |(e & ~mk & sev) & (ctl[0] | ctl[1]);
		n = |(e & ~mk & ~sev) & (ctl[0] | ctl[2]);
		if (f | n)
			q[0].push_back({f, n});
		e_st = e_st | e;
		e_ds = e_ds | {|(e & ~mk) & ctl[0], |(e & ~sev), |(e & sev)};
		i_far.ev(e);
	end
	endtask
	task chk_st;
	begin
		rd(`BEUH_OFS_STAT, {28'h000_0000, e_st}, `BEUH_RESP_OK);
		rd(`BEUH_OFS_DSTAT, {29'h0000_0000, e_ds}, `BEUH_RESP_OK);
		{e_st, e_ds} = 7'h00;
	end
	endtask
	// ****
	// clock, monitor and timeout
	// ****
	initial
		forever #20 i_sys_clk = ~i_sys_clk;
	always @(posedge i_sys_clk)
	begin
		cyc = cyc + 1;
		if (o_msg_fatal | o_msg_nonfatal)
			chk("msg", {o_msg_fatal, o_msg_nonfatal}, pop(0));
		if (o_fwd_vld)
			chk("fwd", {o_fwd_kind, o_fwd_poison, o_fwd_ca}, pop(1));
		if (o_dly_rsp_vld)
			chk("dly", {o_dly_tabort, o_dly_normal, o_dly_normal ? o_dly_data
				: 32'h0000_0000}, pop(2));
		if (o_bvalid && i_bready)
			chk("bresp", {o_bresp, 32'h0000_0000}, pop(3));
		if (o_rvalid && i_rready)
			chk("rdata", {o_rresp, o_rdata}, pop(3));
		if (cyc == 20000)
		begin
			err_total = err_total + 1;
			end_of_test;
		end
	end
	// ****
	// scenarios
	// ****
	initial
	begin
		{ctl, mk, sev, e_st, e_ds} = {12'h00f, 7'h00};
		{cs[0], cs[1], cs[2], cs[3], cs[4]} = {16'h00f1, 16'h1051, 16'h1052,
			16'h1054, 16'h1058};
		{cs[5], cs[6], cs[7], cs[8], cs[9]} = {16'h1053, 16'h1252, 16'h2053,
			16'h4053, 16'h1f5f};
		repeat (2) @(posedge i_sys_clk);
		i_rst_b <= 1'b1;
		@(posedge i_sys_clk);
		rd(`BEUH_OFS_SEV, 32'h0000_000f, `BEUH_RESP_OK);
		rd(`BEUH_OFS_CTRL, 32'h0000_0000, `BEUH_RESP_OK);
		rd(8'h20, 32'h0000_0000, `BEUH_RESP_ERR);
		wr(8'h22, 4'hf, `BEUH_RESP_ERR);
		wr(`BEUH_OFS_STAT, 4'hf, `BEUH_RESP_OK);
		chk_st;
		for (j = 0; j < 10; j = j + 1)
		begin
			{ctl, mk, sev, evm} = cs[j];
			wr(`BEUH_OFS_CTRL, ctl, `BEUH_RESP_OK);
			wr(`BEUH_OFS_MASK, mk, `BEUH_RESP_OK);
			wr(`BEUH_OFS_SEV, sev, `BEUH_RESP_OK);
			fire(evm);
			chk_st;
		end
		wr(`BEUH_OFS_IMASK, 4'h1, `BEUH_RESP_OK);
		for (j = 1; j < 3; j = j + 1)
		begin
			fire(j[3:0]);
			@(posedge i_sys_clk);
			chk("irq", o_irq, j == 1);
			chk_st;
			chk("irq", o_irq, 1'b0);
		end
		for (j = 0; j < 8; j = j + 1)
		begin
			rnd = lfsr(rnd);
			tab = rnd[0] ^ j[0];
			q[1].push_back({j[2:1], tab & ~j[2], tab & j[2]});
			i_far.sec(j[2:1], tab, j != 7);
		end
		for (m = 0; m < 2; m = m + 1)
		begin
			wr(`BEUH_OFS_CTRL, {m[0], 3'h0}, `BEUH_RESP_OK);
			for (j = 0; j < 8; j = j + 1)
			begin
				rnd = lfsr(rnd);
				tab = j[1:0] == `BEUH_CS_CA || (j[1:0] == `BEUH_CS_UR && m[0]);
				q[2].push_back({tab, ~tab, tab ? 32'h0000_0000 : (j[1:0] ==
					`BEUH_CS_UR && !j[2]) ? `BEUH_ONES : rnd});
				i_far.dly(j[2], j[1:0], rnd, j != 7);
			end
		end
		repeat (3) @(posedge i_sys_clk);
		chk("left", q[0].size() + q[1].size() + q[2].size() + q[3].size(), 0);
		end_of_test;
	end
endmodule // beuh_top_tb
